// *** src/mpr_consts.svh ***
// register offsets, field positions, reset values and counts of the option bank
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH
`define MPR_ADR_PINFN 8'h93
`define MPR_ADR_OPTION 8'h94
`define MPR_ADR_FLAGS 8'h95
`define MPR_RST_PINFN 8'h05
`define MPR_RST_OPTION 8'h00
`define MPR_RST_FLAGS 8'h00
`define MPR_BIT_LOWSUP 7
`define MPR_BIT_CMP 6
`define MPR_BIT_TOUCH 5
`define MPR_BIT_CONV 4
`define MPR_BIT_EXT2 2
`define MPR_BIT_PXI 1
`define MPR_BIT_T3 0
`define MPR_FLAG_MASK 8'hF7
`define MPR_T0_DIV_W 6
`define MPR_T3_PER0 32768
`define MPR_T3_PER1 4096
`define MPR_T3_PER2 2048
`define MPR_T3_PER3 512
`define MPR_WDT_MS0 400
`define MPR_WDT_MS1 200
`define MPR_WDT_MS2 100
`define MPR_WDT_MS3 50
`define MPR_ADC_DIV0 6'd32
`define MPR_ADC_DIV1 6'd16
`define MPR_ADC_DIV2 6'd8
`define MPR_ADC_DIV3 6'd4
`endif

// *** src/mpr_pkg.sv ***
// types shared by the option register bank
package mpr_pkg;
   // pin function select register layout
   typedef struct packed {
      logic serial_pin_select;
      logic timer2_toggle_out_en;
      logic timer1_toggle_out_en;
      logic timer0_div_out_en;
      logic [1:0] port2_pin1_mode;
      logic [1:0] port2_pin0_mode;
   } mpr_pinfn_t;
   // misc option register layout
   typedef struct packed {
      logic single_wire_serial_en;
      logic timer3_clock_source;
      logic [1:0] watchdog_period_select;
      logic [1:0] converter_clock_divider;
      logic [1:0] timer3_period_select;
   } mpr_option_t;
   // cpu vectoring acknowledges, one-cycle pulses
   typedef struct packed {
      logic comparator;
      logic ext_irq2;
      logic pin_change;
      logic timer3;
   } mpr_ack_t;
endpackage : mpr_pkg

// *** src/mpr_regs.sv ***
// pin function, option and interrupt flag register bank on the sfr bus
//
// How it works
// - pin select 0 routes serial to P31/P30, 1 to P16/P02
// - enabled P1.0 toggles on each timer2 overflow
// - enabled P3.5 carries timer1 overflow rate divided by two
// - enabled P3.4 carries timer0 overflow rate divided by 64
// - two-bit mode fields for P2.1 and P2.0, reset to 01
// - single-wire mode puts tx and rx on P3.1 or P1.6
// - timer3 clock is slow clock, or slow clock over 0.75
// - watchdog period field 400/200/100/50 ms, resets to 00
// - converter clock is system clock over 32/16/8/4
// - timer3 period 32768/4096/2048/512 timer3 clocks
// - low supply flag bit 7 set while low, cleared by 7Fh
// - comparator flag bit 6, cleared by vectoring or BFh
// - touch flag bit 5, cleared by DFh or touch start
// - clearing the touch flag also clears both touch channel flags
// - converter flag bit 4, cleared by EFh or converter start
// - ext irq2 flag bit 2 set on each pin falling edge
// - ext irq2 flag cleared by vectoring or FBh
// - timer3 flag bit 0 set at period end, cleared by vector or FEh
// - pin change flag bit 1, cleared by vectoring or FDh
`timescale 1ns/1ps
`default_nettype none
`include "mpr_consts.svh"
module mpr_regs import mpr_pkg::*; #(
   parameter int unsigned T3_PER0 = `MPR_T3_PER0  // longest timer3 period
) (
   input wire logic mclk_i,                   // 25 MHz system clock
   input wire logic resetn_i,                 // sync reset, active low
   input wire logic [7:0] sfr_addr_i,         // sfr address
   input wire logic [7:0] sfr_wdata_i,        // sfr write data
   input wire logic sfr_we_i,                 // sfr write strobe
   input wire logic sfr_re_i,                 // sfr read strobe
   output logic [7:0] sfr_rdata_o,            // read data, valid cycle after re
   input wire logic serial_txd_i,             // transmit bit from serial port
   output logic serial_rxd_o,                 // receive bit to serial port
   input wire logic p30_i,                    // P3.0 pin level
   input wire logic p31_i,                    // P3.1 pin level
   input wire logic p02_i,                    // P0.2 pin level
   input wire logic p16_i,                    // P1.6 pin level
   output logic p31_o,                        // P3.1 drive value
   output logic p31_oe_o,                     // P3.1 drive enable
   output logic p16_o,                        // P1.6 drive value
   output logic p16_oe_o,                     // P1.6 drive enable
   input wire logic t0_ovf_i,                 // timer0 overflow pulse
   input wire logic t1_ovf_i,                 // timer1 overflow pulse
   input wire logic t2_ovf_i,                 // timer2 overflow pulse
   output logic p10_o,                        // P1.0 timer2 toggle out
   output logic p10_oe_o,                     // P1.0 drive enable
   output logic p35_o,                        // P3.5 timer1 toggle out
   output logic p35_oe_o,                     // P3.5 drive enable
   output logic p34_o,                        // P3.4 timer0 divided out
   output logic p34_oe_o,                     // P3.4 drive enable
   output logic [1:0] port2_pin1_mode_o,      // P2.1 mode
   output logic [1:0] port2_pin0_mode_o,      // P2.0 mode
   output logic [1:0] watchdog_period_select_o, // watchdog period code
   output logic converter_clk_tick_o,         // converter clock enable pulse
   input wire logic slow_osc_clock_i,         // slow clock, foreign domain
   input wire logic slow_fast_clock_i,        // slow/0.75 clock, foreign domain
   output logic timer3_ovf_o,                 // timer3 period end pulse
   input wire logic low_supply_detect_i,      // supply low level, async
   input wire logic comparator_output_i,      // comparator trigger pulse
   input wire logic touch_done_i,             // touch conversion end pulse
   input wire logic touch_conversion_start_i, // touch start bit set pulse
   output logic touch_chan_clr_o,             // clears touch channel a/b flags
   input wire logic converter_done_i,         // converter end pulse
   input wire logic converter_start_bit_i,    // converter start bit set pulse
   input wire logic ext_irq2_pin_i,           // external irq2 pin, async
   input wire logic pin_change_i,             // enabled pin change pulse
   input wire mpr_ack_t ack_i,                // vectoring acknowledges
   output logic [7:0] flags_o                 // flag register contents
);
   ////////////////////////////////////////////////////////////////////////
   // declarations
   mpr_pinfn_t pinfn_q;
   mpr_option_t option_q;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [1:0] rx30_q, rx31_q, rx02_q, rx16_q, slow_q, fast_q, lvd_q, irq2_q;
   logic irq2_d2_q;
   logic t2_tog_q;
   logic t1_tog_q;
   logic [`MPR_T0_DIV_W-1:0] t0_div_q;
   logic [5:0] adc_cnt_q;
   logic [5:0] adc_cnt_d;
   logic adc_last;
   logic wr_pinfn, wr_option, wr_flags;
   logic [7:0] rd_mux;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic irq2_fall;
   logic t3_ovf;
   logic rx_sel;
   logic tx31_val, tx31_oe, tx16_val, tx16_oe;

   // converter divide ratio
   function automatic logic [5:0] adc_div(input logic [1:0] sel);
      case (sel)
         2'd0: adc_div = `MPR_ADC_DIV0;
         2'd1: adc_div = `MPR_ADC_DIV1;
         2'd2: adc_div = `MPR_ADC_DIV2;
         default: adc_div = `MPR_ADC_DIV3;
      endcase
   endfunction : adc_div

   ////////////////////////////////////////////////////////////////////////
   // address decode and read mux; unmapped reads return zero
   assign wr_pinfn = sfr_we_i && (sfr_addr_i == `MPR_ADR_PINFN);
   assign wr_option = sfr_we_i && (sfr_addr_i == `MPR_ADR_OPTION);
   assign wr_flags = sfr_we_i && (sfr_addr_i == `MPR_ADR_FLAGS);
   assign rd_mux = (sfr_addr_i == `MPR_ADR_PINFN) ? pinfn_q :
                   (sfr_addr_i == `MPR_ADR_OPTION) ? option_q :
                   (sfr_addr_i == `MPR_ADR_FLAGS) ? flags_q : 8'h00;

   // configuration registers
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         pinfn_q <= `MPR_RST_PINFN;
         option_q <= `MPR_RST_OPTION;
         sfr_rdata_o <= 8'h00;
      end
      else
      begin
         if (wr_pinfn)
            pinfn_q <= sfr_wdata_i;
         if (wr_option)
            option_q <= sfr_wdata_i;
         sfr_rdata_o <= sfr_re_i ? rd_mux : sfr_rdata_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for every foreign input
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         rx30_q <= 2'b11;
         rx31_q <= 2'b11;
         rx02_q <= 2'b11;
         rx16_q <= 2'b11;
         slow_q <= 2'b00;
         fast_q <= 2'b00;
         lvd_q <= 2'b00;
         irq2_q <= 2'b11;
         irq2_d2_q <= 1'b1;
      end
      else
      begin
         rx30_q <= {rx30_q[0], p30_i};
         rx31_q <= {rx31_q[0], p31_i};
         rx02_q <= {rx02_q[0], p02_i};
         rx16_q <= {rx16_q[0], p16_i};
         slow_q <= {slow_q[0], slow_osc_clock_i};
         fast_q <= {fast_q[0], slow_fast_clock_i};
         lvd_q <= {lvd_q[0], low_supply_detect_i};
         irq2_q <= {irq2_q[0], ext_irq2_pin_i};
         irq2_d2_q <= irq2_q[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial pin routing; single-wire mode drives low only, pin pulled high
   assign rx_sel = pinfn_q.serial_pin_select;
   assign tx31_val = option_q.single_wire_serial_en ? 1'b0 : serial_txd_i;
   assign tx31_oe = ~rx_sel & (~option_q.single_wire_serial_en | ~serial_txd_i);
   assign tx16_val = tx31_val;
   assign tx16_oe = rx_sel & (~option_q.single_wire_serial_en | ~serial_txd_i);

   // registered pin drive and receive selection
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         p31_o <= 1'b1;
         p31_oe_o <= 1'b0;
         p16_o <= 1'b1;
         p16_oe_o <= 1'b0;
         serial_rxd_o <= 1'b1;
      end
      else
      begin
         p31_o <= tx31_val;
         p31_oe_o <= tx31_oe;
         p16_o <= tx16_val;
         p16_oe_o <= tx16_oe;
         if (option_q.single_wire_serial_en)
            serial_rxd_o <= rx_sel ? rx16_q[1] : rx31_q[1];
         else
            serial_rxd_o <= rx_sel ? rx02_q[1] : rx30_q[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timer overflow divided outputs, dividers free-run so enable is glitch-free
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         t2_tog_q <= 1'b0;
         t1_tog_q <= 1'b0;
         t0_div_q <= '0;
         p10_o <= 1'b0;
         p35_o <= 1'b0;
         p34_o <= 1'b0;
         p10_oe_o <= 1'b0;
         p35_oe_o <= 1'b0;
         p34_oe_o <= 1'b0;
      end
      else
      begin
         t2_tog_q <= t2_tog_q ^ t2_ovf_i;
         t1_tog_q <= t1_tog_q ^ t1_ovf_i;
         t0_div_q <= t0_div_q + `MPR_T0_DIV_W'(t0_ovf_i);
         p10_o <= t2_tog_q;
         p35_o <= t1_tog_q;
         p34_o <= t0_div_q[`MPR_T0_DIV_W-1];
         p10_oe_o <= pinfn_q.timer2_toggle_out_en;
         p35_oe_o <= pinfn_q.timer1_toggle_out_en;
         p34_oe_o <= pinfn_q.timer0_div_out_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // converter clock enable; a changed divider applies at once, a count at or past the new end wraps at the next edge
   assign adc_last = (adc_cnt_q >= adc_div(option_q.converter_clock_divider) - 6'd1);
   assign adc_cnt_d = adc_last ? 6'd0 : adc_cnt_q + 6'd1;

   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         adc_cnt_q <= 6'd0;
         converter_clk_tick_o <= 1'b0;
      end
      else
      begin
         adc_cnt_q <= adc_cnt_d;
         converter_clk_tick_o <= adc_last;
      end
   end

   // timer3 on the selected slow clock
   mpr_timer3 #(
      .PER0 (T3_PER0)
   ) u_timer3 (
      .mclk_i (mclk_i),
      .resetn_i (resetn_i),
      .slow_s_i (slow_q[1]),
      .fast_s_i (fast_q[1]),
      .src_sel_i (option_q.timer3_clock_source),
      .psc_i (option_q.timer3_period_select),
      .overflow_o (t3_ovf)
   );

   ////////////////////////////////////////////////////////////////////////
   // flag sets and clears; set beats clear in the same cycle
   assign irq2_fall = irq2_d2_q & ~irq2_q[1];
   assign flag_set = {lvd_q[1], comparator_output_i, touch_done_i, converter_done_i,
                      1'b0, irq2_fall, pin_change_i, t3_ovf};
   assign flag_clr[`MPR_BIT_LOWSUP] = wr_flags & ~sfr_wdata_i[`MPR_BIT_LOWSUP];
   assign flag_clr[`MPR_BIT_CMP] = (wr_flags & ~sfr_wdata_i[`MPR_BIT_CMP]) | ack_i.comparator;
   assign flag_clr[`MPR_BIT_TOUCH] = (wr_flags & ~sfr_wdata_i[`MPR_BIT_TOUCH]) |
                                     touch_conversion_start_i;
   assign flag_clr[`MPR_BIT_CONV] = (wr_flags & ~sfr_wdata_i[`MPR_BIT_CONV]) |
                                    converter_start_bit_i;
   assign flag_clr[3] = 1'b0;
   assign flag_clr[`MPR_BIT_EXT2] = (wr_flags & ~sfr_wdata_i[`MPR_BIT_EXT2]) | ack_i.ext_irq2;
   assign flag_clr[`MPR_BIT_PXI] = (wr_flags & ~sfr_wdata_i[`MPR_BIT_PXI]) | ack_i.pin_change;
   assign flag_clr[`MPR_BIT_T3] = (wr_flags & ~sfr_wdata_i[`MPR_BIT_T3]) | ack_i.timer3;
   assign flags_d = ((flags_q & ~flag_clr) | flag_set) & `MPR_FLAG_MASK;

   // flag register and touch channel clear pulse
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         flags_q <= `MPR_RST_FLAGS;
         touch_chan_clr_o <= 1'b0;
      end
      else
      begin
         flags_q <= flags_d;
         touch_chan_clr_o <= flag_clr[`MPR_BIT_TOUCH];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered copies of configuration fields, timer3 overflow and flags
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         port2_pin1_mode_o <= 2'b01;
         port2_pin0_mode_o <= 2'b01;
         watchdog_period_select_o <= 2'b00;
         timer3_ovf_o <= 1'b0;
         flags_o <= `MPR_RST_FLAGS;
      end
      else
      begin
         port2_pin1_mode_o <= pinfn_q.port2_pin1_mode;
         port2_pin0_mode_o <= pinfn_q.port2_pin0_mode;
         watchdog_period_select_o <= option_q.watchdog_period_select;
         timer3_ovf_o <= t3_ovf;
         flags_o <= flags_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   set_beats_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      flag_set[`MPR_BIT_EXT2] |=> flags_q[`MPR_BIT_EXT2])
      else $error("ext irq2 flag lost a set");
   write_one_keeps_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_flags && sfr_wdata_i[`MPR_BIT_CONV] && !converter_start_bit_i && flags_q[`MPR_BIT_CONV]
      |=> flags_q[`MPR_BIT_CONV]) else $error("converter flag lost on a one write");
   lowsup_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_flags && !sfr_wdata_i[`MPR_BIT_LOWSUP] && !lvd_q[1] |=> !flags_q[`MPR_BIT_LOWSUP])
      else $error("low supply flag not cleared");
   cmp_vector_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      ack_i.comparator && !comparator_output_i |=> !flags_q[`MPR_BIT_CMP])
      else $error("comparator flag survived vectoring");
   touch_chain_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      touch_conversion_start_i |=> touch_chan_clr_o) else $error("touch channels not cleared");
   conv_start_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      converter_start_bit_i && !converter_done_i |=> !flags_q[`MPR_BIT_CONV])
      else $error("converter flag survived start");
   irq2_edge_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      $fell(irq2_q[1]) |=> flags_q[`MPR_BIT_EXT2]) else $error("irq2 edge missed");
   t3_flag_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      t3_ovf |=> flags_q[`MPR_BIT_T3] && timer3_ovf_o) else $error("timer3 flag not set");
   serial_route_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !option_q.single_wire_serial_en && $stable(pinfn_q) && pinfn_q.serial_pin_select
      |=> !p31_oe_o) else $error("P3.1 driven while serial on P1.6");
   t0_div_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      t0_ovf_i && t0_div_q == 6'd31 |=> ##1 p34_o) else $error("timer0 divider wrong");
   mode_reset_a: assert property (@(posedge mclk_i)
      !resetn_i |=> pinfn_q.port2_pin0_mode == 2'b01) else $error("P2.0 mode reset wrong");
   adc_tick_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      option_q.converter_clock_divider == 2'b11 && $stable(option_q) && converter_clk_tick_o
      |=> !converter_clk_tick_o [*3]) else $error("converter clock spacing wrong");
   flag_wr_c: cover property (@(posedge mclk_i) disable iff (!resetn_i) wr_flags && |flags_q);
   irq2_c: cover property (@(posedge mclk_i) disable iff (!resetn_i) irq2_fall && wr_flags);
   single_wire_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      option_q.single_wire_serial_en && p16_oe_o);
endmodule : mpr_regs
`default_nettype wire

// *** src/mpr_timer3.sv ***
// timer3 period counter with selectable clock source
`timescale 1ns/1ps
`default_nettype none
`include "mpr_consts.svh"
module mpr_timer3 import mpr_pkg::*; #(
   parameter int unsigned PER0 = `MPR_T3_PER0
) (
   input wire logic mclk_i,        // system clock
   input wire logic resetn_i,      // sync reset, active low
   input wire logic slow_s_i,      // synced slow clock level
   input wire logic fast_s_i,      // synced slow/0.75 clock level
   input wire logic src_sel_i,     // 1 selects the faster source
   input wire logic [1:0] psc_i,   // period select
   output logic overflow_o         // one-cycle pulse at period end
);
   logic slow_d1_q;
   logic fast_d1_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic tick;
   logic last;
   logic [15:0] period_m1;

   // period in timer3 clocks minus one
   function automatic logic [15:0] per_m1(input logic [1:0] sel);
      case (sel)
         2'd0: per_m1 = 16'(PER0 - 1);
         2'd1: per_m1 = 16'(`MPR_T3_PER1 - 1);
         2'd2: per_m1 = 16'(`MPR_T3_PER2 - 1);
         default: per_m1 = 16'(`MPR_T3_PER3 - 1);
      endcase
   endfunction : per_m1

   // rising edge of the chosen source is one timer3 clock
   assign tick = src_sel_i ? (fast_s_i & ~fast_d1_q) : (slow_s_i & ~slow_d1_q);
   assign period_m1 = per_m1(psc_i);
   assign last = tick && (cnt_q >= period_m1);
   assign cnt_d = last ? 16'h0000 : (tick ? cnt_q + 16'h0001 : cnt_q);

   // a shortened period after a select change ends at the next timer3 clock, never wraps 64k
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         slow_d1_q <= 1'b0;
         fast_d1_q <= 1'b0;
         cnt_q <= 16'h0000;
         overflow_o <= 1'b0;
      end
      else
      begin
         slow_d1_q <= slow_s_i;
         fast_d1_q <= fast_s_i;
         cnt_q <= cnt_d;
         overflow_o <= last;
      end
   end

   t3_count_bound_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      cnt_q <= per_m1(2'd0) || cnt_q <= per_m1(2'd1))
      else $error("timer3 count ran past the longest period");
   t3_overflow_cause_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      overflow_o |-> $past(tick) && $past(cnt_q) >= $past(period_m1))
      else $error("timer3 overflow without a completed period");
   t3_overflow_c: cover property (@(posedge mclk_i) disable iff (!resetn_i) overflow_o);
endmodule : mpr_timer3
`default_nettype wire

// *** testbench/mpr_cpu_model.sv ***
// cpu side of the sfr bus: byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module mpr_cpu_model (
   input wire logic mclk_i, // system clock
   output logic [7:0] addr_o, // sfr address
   output logic [7:0] wdata_o, // write data
   output logic we_o, // write strobe
   output logic re_o, // read strobe
   input wire logic [7:0] rdata_i // read data
);
   // idle bus at time zero, no strobe before reset ends
   initial
   begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      we_o = 1'b0;
      re_o = 1'b0;
   end
   ////////////////////////////////////////
   // strobe held until the taking edge, data scrambled after it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      wdata_o <= d;
      we_o <= 1'b1;
      @(posedge mclk_i);
      we_o <= 1'b0;
      wdata_o <= ~d;
      #1;
   endtask : wr
   // read data is registered, so it is taken once the read edge landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      re_o <= 1'b1;
      @(posedge mclk_i);
      re_o <= 1'b0;
      #1;
      d = rdata_i;
   endtask : rd
endmodule : mpr_cpu_model
`default_nettype wire

// *** testbench/tb_misc_pin_option_intflag_regs.sv ***
// self-checking bench of the option and flag register bank
`timescale 1ns/1ps
`default_nettype none
module tb_misc_pin_option_intflag_regs import mpr_pkg::*;;
   logic mclk_i = 1'b0, resetn_i = 1'b0, serial_txd_i = 1'b1, p30_i = 1'b1, p02_i = 1'b1;
   logic slow_osc_clock_i = 1'b0, slow_fast_clock_i = 1'b0, low_supply_detect_i = 1'b0;
   logic ext_irq2_pin_i = 1'b1, b, t;
   logic [7:0] ev = 8'h00, st = 8'h00, d, sfr_addr_i, sfr_wdata_i, sfr_rdata_o, flags_o;
   logic [2:0] tov = 3'b000;
   mpr_ack_t ack = '0;
   logic sfr_we_i, sfr_re_i, serial_rxd_o, p31_o, p31_oe_o, p16_o, p16_oe_o, p10_o, p10_oe_o;
   logic p35_o, p35_oe_o, p34_o, p34_oe_o, converter_clk_tick_o, timer3_ovf_o, touch_chan_clr_o;
   logic [1:0] port2_pin1_mode_o, port2_pin0_mode_o, watchdog_period_select_o;
   // pins have pull-ups, so a released pin reads high
   wire p31_i = p31_oe_o ? p31_o : 1'b1;
   wire p16_i = p16_oe_o ? p16_o : 1'b1;
   wire [2:0] tout = {p10_o, p35_o, p34_o};
   wire [5:0] modes = {port2_pin1_mode_o, port2_pin0_mode_o, watchdog_period_select_o};
   int checks = 0, fails = 0, mflag = 0, t3n = 0, cycn = 0, n;
   int mreg[int] = '{8'h93: 8'h05, 8'h94: 8'h00};
   int fb[4] = '{6, 5, 4, 1};
   logic [7:0] sc[4] = '{8'h00, 8'h20, 8'h10, 8'h00};
   mpr_ack_t kc[4] = '{4'h8, 4'h0, 4'h0, 4'h2};
   mpr_cpu_model i_cpu (.mclk_i, .addr_o(sfr_addr_i), .wdata_o(sfr_wdata_i), .we_o(sfr_we_i),
      .re_o(sfr_re_i), .rdata_i(sfr_rdata_o));
   // short timer3 period keeps the run brief
   mpr_regs #(.T3_PER0(8)) i_dut (.mclk_i, .resetn_i, .sfr_addr_i, .sfr_wdata_i, .sfr_we_i,
      .sfr_re_i, .sfr_rdata_o, .serial_txd_i, .serial_rxd_o, .p30_i, .p31_i, .p02_i, .p16_i,
      .p31_o, .p31_oe_o, .p16_o, .p16_oe_o, .t0_ovf_i(tov[0]), .t1_ovf_i(tov[1]),
      .t2_ovf_i(tov[2]), .p10_o, .p10_oe_o, .p35_o, .p35_oe_o, .p34_o, .p34_oe_o,
      .port2_pin1_mode_o, .port2_pin0_mode_o, .watchdog_period_select_o, .converter_clk_tick_o,
      .slow_osc_clock_i, .slow_fast_clock_i, .timer3_ovf_o, .low_supply_detect_i,
      .comparator_output_i(ev[6]), .touch_done_i(ev[5]), .touch_conversion_start_i(st[5]),
      .touch_chan_clr_o, .converter_done_i(ev[4]), .converter_start_bit_i(st[4]),
      .ext_irq2_pin_i, .pin_change_i(ev[1]), .ack_i(ack), .flags_o);
   always #20 mclk_i = ~mclk_i;
   // overflow counter and hang guard
   always @(posedge mclk_i)
   begin
      cycn++;
      if (timer3_ovf_o === 1'b1)
         t3n++;
      if (cycn == 20000)
      begin
         fails++;
         results();
      end
   end
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask : cyc
   // model first, then the bus write
   task automatic wm(input logic [7:0] a, input logic [7:0] v);
      if (a == 8'h95)
         mflag = mflag & v;
      else if (mreg.exists(a))
         mreg[a] = v;
      i_cpu.wr(a, v);
   endtask : wm
   task automatic rc(input logic [7:0] a);
      logic [7:0] v;
      i_cpu.rd(a, v);
      chk("rdata", (a == 8'h95) ? 8'(mflag) : (mreg.exists(a) ? 8'(mreg[a]) : 8'h00), v);
   endtask : rc
   // one-cycle set, clear and vectoring pulses; a set beats every clear
   task automatic pl(input logic [7:0] e, input logic [7:0] s, input mpr_ack_t k);
      @(posedge mclk_i);
      ev <= e;
      st <= s;
      ack <= k;
      @(posedge mclk_i);
      ev <= 8'h00;
      st <= 8'h00;
      ack <= '0;
      #1;
      mflag = (mflag & ~int'(s | {1'b0, k[3], 3'b000, k[2:0]})) | e;
   endtask : pl
   task automatic tp(input int j, input int k);
      repeat (k)
      begin
         @(posedge mclk_i);
         tov <= 3'(1 << j);
         @(posedge mclk_i);
         tov <= 3'b000;
      end
      cyc(2);
   endtask : tp
   task automatic se(input logic f, input int k);
      repeat (k)
      begin
         @(posedge mclk_i);
         {slow_fast_clock_i, slow_osc_clock_i} <= f ? 2'b10 : 2'b01;
         repeat (3) @(posedge mclk_i);
         {slow_fast_clock_i, slow_osc_clock_i} <= 2'b00;
         cyc(3);
      end
      cyc(6);
   endtask : se
   task automatic wt(output int k);
      k = 0;
      do
      begin
         cyc(1);
         k++;
      end
      while (converter_clk_tick_o !== 1'b1 && k < 99);
   endtask : wt
   task automatic results();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   ////////////////////////////////////////
   initial
   begin
      void'($urandom(89071));
      repeat (5) @(posedge mclk_i);
      resetn_i <= 1'b1;
      for (int a = 8'h93; a < 8'h97; a++)
         rc(8'(a));
      repeat (4)
      begin
         d = 8'($urandom);
         wm(8'h93, d);
         wm(8'h94, 8'($urandom) & 8'h7F);
         rc(8'h93);
         rc(8'h94);
         chk("modes", {d[3:0], 2'(mreg[8'h94] >> 4)}, modes);
      end
      $display("test registers done");
      foreach (fb[i])
      begin
         pl(8'(1 << fb[i]), 8'h00, '0);
         chk("flags", 8'(mflag), flags_o);
         wm(8'h95, ~8'(1 << fb[i]));
         t = touch_chan_clr_o;
         cyc(1);
         chk("flags", 8'(mflag), flags_o);
         if (fb[i] == 5)
            chk("tclr", 8'h01, t | touch_chan_clr_o);
         pl(8'(1 << fb[i]), 8'h00, '0);
         pl(8'h00, sc[i], kc[i]);
         chk("flags", 8'(mflag), flags_o);
      end
      fork
         wm(8'h95, 8'h00);
         pl(8'h10, 8'h00, '0);
      join
      chk("flags", 8'(mflag), flags_o);
      @(posedge mclk_i);
      ext_irq2_pin_i <= 1'b0;
      cyc(5);
      mflag = mflag | 4;
      pl(8'h00, 8'h00, 4'h4);
      chk("flags", 8'(mflag), flags_o);
      @(posedge mclk_i);
      low_supply_detect_i <= 1'b1;
      ext_irq2_pin_i <= 1'b1;
      cyc(5);
      mflag = mflag | 8'h80;
      wm(8'h95, 8'h7F);
      mflag = mflag | 8'h80;
      chk("flags", 8'(mflag), flags_o);
      @(posedge mclk_i);
      low_supply_detect_i <= 1'b0;
      ext_irq2_pin_i <= 1'b0;
      cyc(5);
      chk("flags", 8'(mflag | 4), flags_o);
      wm(8'h95, 8'h7B);
      chk("flags", 8'(mflag), flags_o);
      $display("test flags done");
      wm(8'h93, 8'h70);
      cyc(1);
      chk("oe", 8'h07, {p10_oe_o, p35_oe_o, p34_oe_o});
      for (int j = 0; j < 3; j++)
      begin
         b = tout[j];
         tp(j, (j == 0) ? 31 : 0);
         chk("tout", b, tout[j]);
         tp(j, 1);
         chk("tout", {~b}, tout[j]);
      end
      wm(8'h93, 8'h00);
      cyc(1);
      chk("oe", 8'h00, {p10_oe_o, p35_oe_o, p34_oe_o});
      for (int s = 0; s < 4; s++)
      begin
         wm(8'h93, 8'(s[1] << 7));
         @(posedge mclk_i);
         {serial_txd_i, p30_i, p02_i} <= {s[0], s[0], ~s[0]};
         cyc(4);
         chk("tx", {2'b11, s[0], 1'b0}, s[1] ? {s[1], p16_oe_o, p16_o, p31_oe_o}
            : {1'b1, p31_oe_o, p31_o, p16_oe_o});
         chk("rx", s[0] ^ s[1], serial_rxd_o);
      end
      wm(8'h94, 8'h80);
      for (int v = 0; v < 2; v++)
      begin
         @(posedge mclk_i);
         serial_txd_i <= v[0];
         cyc(4);
         chk("wire1", {~v[0], v[0]}, {p16_oe_o, serial_rxd_o});
      end
      $display("test pins done");
      for (int c = 0; c < 4; c++)
      begin
         wm(8'h94, 8'(c << 2));
         wt(n);
         wt(n);
         chk("tick", 8'(32 >> c), 8'(n));
      end
      t3n = 0;
      se(1'b0, 7);
      chk("t3", 8'h00, 8'(t3n));
      se(1'b0, 1);
      chk("t3", 8'h01, 8'(t3n));
      mflag = mflag | 1;
      chk("flags", 8'(mflag), flags_o);
      pl(8'h00, 8'h00, 4'h1);
      wm(8'h94, 8'h40);
      se(1'b1, 8);
      chk("t3", 8'h02, 8'(t3n));
      mflag = mflag | 1;
      wm(8'h95, 8'hFE);
      chk("flags", 8'(mflag), flags_o);
      $display("test timers done");
      results();
   end
endmodule : tb_misc_pin_option_intflag_regs
`default_nettype wire
